// [hw/urbf_framer.sv]
// request block framer: strips/snoops requests, packs blocks per minislot
`timescale 1ns/1ps
`default_nettype none
module urbf_framer
  import urbf_pkg::*;
#(
  parameter int unsigned DEPTH   = 16,
  parameter int unsigned WIN_LOG = 8
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  // register port
  input  wire logic [REG_AW-1:0]      reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_we_i,
  input  wire logic                   reg_re_i,
  output logic      [31:0]            reg_rdata_o,
  // upstream data stream
  input  wire logic                   dat_valid_i,
  input  wire logic [7:0]             dat_byte_i,
  input  wire logic                   dat_sa_req_i,
  output logic                        dat_valid_o,
  output logic      [7:0]             dat_byte_o,
  // request descriptors from the burst parser
  input  wire logic                   req_valid_i,
  input  wire logic                   req_piggy_i,
  input  wire logic                   req_frag_concat_i,
  input  wire logic [2:0]             req_cluster_i,
  input  wire logic                   req_cluster_valid_i,
  input  wire logic                   req_units_i,
  input  wire logic [3:0]             req_iuc_i,
  input  wire logic [15:0]            req_size_i,
  input  wire logic [13:0]            req_granted_flow_i,
  input  wire logic [13:0]            req_carried_flow_i,
  input  wire logic                   req_carried_present_i,
  input  wire logic [31:0]            req_start_ms_i,
  input  wire logic [31:0]            req_session_i,
  input  wire logic                   ms_end_i,
  // contention opportunity outcomes
  input  wire logic                   cont_opp_i,
  input  wire logic                   cont_coll_i,
  // request path packet output
  output logic                        blk_valid_o,
  output logic                        blk_sop_o,
  output logic                        blk_eop_o,
  output logic      [BLK_W-1:0]       blk_data_o,
  output logic                        seg_begin_o,
  output logic                        seg_end_o,
  output logic      [$clog2(DEPTH+1)-1:0] seg_blocks_o
);
  localparam int unsigned IW  = $clog2(DEPTH);
  localparam int unsigned CW  = $clog2(DEPTH+1);
  localparam int unsigned WIN = 2**WIN_LOG;

  if (DEPTH < 2 || (2**IW) != DEPTH || WIN_LOG < 1 || WIN_LOG > 8) begin : g_bad_param
    $error("DEPTH must be a power of two of at least 2, WIN_LOG must lie in 1..8");
  end

  // status byte then block assembly in serial order
  function automatic logic [BLK_W-1:0] build_block(
    input logic [2:0] cl, input logic clv, input logic un, input logic pg, input logic [3:0] coll,
    input logic [3:0] interval_usage_code, input logic [15:0] sz, input logic [13:0] gr, input logic [13:0] ca,
    input logic cap, input logic [31:0] ms, input logic [31:0] ss);
    logic [7:0] st;
    st = {HDR_VER_1, cl, clv, un, pg};
    return {st, coll, 1'b0, interval_usage_code, sz, gr, (cap ? ca : 14'h0000), ms, ss};
  endfunction : build_block

  // number of ascending thresholds the percentage exceeds
  function automatic logic [2:0] collision_bin_level(input logic [15:0] pct, input logic [NUM_THR*THR_W-1:0] thr);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NUM_THR; i++) begin
      if (pct > {8'h00, thr[i*THR_W +: THR_W]}) n = n + 3'h1;
    end
    return n;
  endfunction : collision_bin_level

  // registers
  logic [1:0]                 ctrl_q;
  logic [NUM_THR*THR_W-1:0]   thr_q;
  logic [31:0]                pkts_q;
  logic [31:0]                drops_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      thr_q  <= {NUM_THR{THR_RST}};
    end else if (reg_we_i) begin
      if (reg_addr_i == REG_CTRL) ctrl_q <= reg_wdata_i[1:0];
      for (int i = 0; i < NUM_THR; i++) begin
        if (reg_addr_i == REG_THR0 + 4'(i)) thr_q[i*THR_W +: THR_W] <= reg_wdata_i[THR_W-1:0];
      end
    end
  end

  logic en;
  logic coll_en;
  assign en      = ctrl_q[CTRL_EN_BIT];
  assign coll_en = ctrl_q[CTRL_COLL_BIT];

  // data stream: while enabled, standalone request frames leave the stream, all else passes as is
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dat_valid_o <= 1'b0;
      dat_byte_o  <= 8'h00;
    end else begin
      dat_valid_o <= dat_valid_i && !(dat_sa_req_i && en);
      dat_byte_o  <= dat_byte_i;
    end
  end

  // sliding collision window over the last WIN contention opportunities
  logic [WIN-1:0]   win_q;
  logic [8:0]       win_hits_q;
  logic [8:0]       win_fill_q;
  logic [15:0]      pct;
  logic             coll_valid;
  logic [2:0]       coll_lvl;
  logic [3:0]       coll_field;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !coll_en) begin
      win_q      <= '0;
      win_hits_q <= 9'h000;
      win_fill_q <= 9'h000;
    end else if (cont_opp_i) begin
      win_q      <= {win_q[WIN-2:0], cont_coll_i};
      win_hits_q <= win_hits_q + {8'h00, cont_coll_i} - {8'h00, win_q[WIN-1]};
      if (win_fill_q != 9'(WIN)) win_fill_q <= win_fill_q + 9'h001;
    end
  end

  // the level only means something once the window has filled
  assign pct        = 16'((32'(win_hits_q) * 32'(PCT_FULL)) >> WIN_LOG);
  assign coll_valid = coll_en && (win_fill_q == 9'(WIN));
  assign coll_lvl   = coll_valid ? collision_bin_level(pct, thr_q) : 3'h0;
  assign coll_field = {!coll_valid, coll_lvl};

  // collector: gathers one minislot's blocks into a bank
  urbf_mem_if #(.W(BLK_W), .AW(IW+1)) mif ();

  urbf_mem #(.W(BLK_W), .AW(IW+1)) u_mem (
    .sys_clk_i (sys_clk_i),
    .mif       (mif)
  );

  logic            col_open_q;
  logic [31:0]     col_ms_q;
  logic [CW-1:0]   col_cnt_q;
  logic            col_bank_q;
  logic            em_busy_q;
  logic            acc;
  logic            close;
  logic            start;
  logic            wr_bank;
  logic [CW-1:0]   wr_idx;
  logic            wr_ok;

  assign acc     = req_valid_i && en && !(req_piggy_i && req_frag_concat_i);
  assign close   = col_open_q && (ms_end_i || (acc && req_start_ms_i != col_ms_q));
  assign start   = close && !em_busy_q;
  assign wr_bank = start ? !col_bank_q : col_bank_q;
  assign wr_idx  = close ? '0 : col_cnt_q;
  // a full bank refuses further requests of the same minislot
  assign wr_ok   = acc && (wr_idx != CW'(DEPTH));

  assign mif.wr_en   = wr_ok;
  assign mif.wr_addr = {wr_bank, wr_idx[IW-1:0]};
  assign mif.wr_data = build_block(req_cluster_i, req_cluster_valid_i, req_units_i, req_piggy_i, coll_field,
                                   req_iuc_i, req_size_i, req_granted_flow_i, req_carried_flow_i,
                                   req_carried_present_i, req_start_ms_i, req_session_i);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      col_open_q <= 1'b0;
      col_ms_q   <= 32'h0;
      col_cnt_q  <= '0;
      col_bank_q <= 1'b0;
    end else begin
      col_bank_q <= wr_bank;
      if (close) begin
        col_open_q <= acc;
        col_cnt_q  <= acc ? CW'(1) : '0;
      end else if (wr_ok) begin
        col_open_q <= 1'b1;
        col_cnt_q  <= col_cnt_q + CW'(1);
      end
      if (acc) col_ms_q <= req_start_ms_i;
    end
  end

  // the emitter only owns one bank, so a second close while busy loses that minislot
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      drops_q <= 32'h0;
    end else if (close && em_busy_q) begin
      drops_q <= drops_q + 32'(col_cnt_q) + 32'(acc && !wr_ok);
    end else if (acc && !wr_ok) begin
      drops_q <= drops_q + 32'h1;
    end
  end

  // emitter: reads a closed bank out as one packet
  urbf_em_state_t  em_state_q;
  logic            em_bank_q;
  logic [CW-1:0]   em_cnt_q;
  logic [CW-1:0]   em_idx_q;
  logic            iss;
  logic            iss_last;

  assign em_busy_q = (em_state_q == URBF_EM_RUN);
  assign iss       = em_busy_q && (em_idx_q < em_cnt_q);
  assign iss_last  = iss && (em_idx_q == em_cnt_q - CW'(1));
  assign mif.rd_en   = iss;
  assign mif.rd_addr = {em_bank_q, em_idx_q[IW-1:0]};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      em_state_q <= URBF_EM_IDLE;
      em_bank_q  <= 1'b0;
      em_cnt_q   <= '0;
      em_idx_q   <= '0;
    end else begin
      case (em_state_q)
        URBF_EM_IDLE: begin
          if (start) begin
            em_state_q <= URBF_EM_RUN;
            em_bank_q  <= col_bank_q;
            em_cnt_q   <= col_cnt_q;
            em_idx_q   <= '0;
          end
        end
        URBF_EM_RUN: begin
          if (iss) em_idx_q <= em_idx_q + CW'(1);
          if (iss_last) em_state_q <= URBF_EM_IDLE;
        end
        default: em_state_q <= URBF_EM_IDLE;
      endcase
    end
  end

  // read pipeline: flags follow the store's registered read data
  logic          s1_valid_q;
  logic          s1_first_q;
  logic          s1_last_q;
  logic [CW-1:0] s1_cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1_valid_q <= 1'b0;
      s1_first_q <= 1'b0;
      s1_last_q  <= 1'b0;
      s1_cnt_q   <= '0;
    end else begin
      s1_valid_q <= iss;
      s1_first_q <= iss && (em_idx_q == '0);
      s1_last_q  <= iss_last;
      s1_cnt_q   <= em_cnt_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      blk_valid_o  <= 1'b0;
      blk_sop_o    <= 1'b0;
      blk_eop_o    <= 1'b0;
      blk_data_o   <= '0;
      seg_begin_o  <= 1'b0;
      seg_end_o    <= 1'b0;
      seg_blocks_o <= '0;
    end else begin
      blk_valid_o <= s1_valid_q;
      blk_sop_o   <= s1_first_q;
      blk_eop_o   <= s1_last_q;
      blk_data_o  <= s1_valid_q ? mif.rd_data : '0;
      if (s1_first_q) begin
        seg_begin_o  <= 1'b1;
        seg_end_o    <= 1'b1;
        seg_blocks_o <= s1_cnt_q;
      end else if (s1_valid_q) begin
        seg_begin_o <= 1'b0;
        seg_end_o   <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pkts_q <= 32'h0;
    end else if (s1_last_q) begin
      pkts_q <= pkts_q + 32'h1;
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_re_i) begin
      reg_rdata_o <= 32'h0;
      case (reg_addr_i)
        REG_CTRL:  reg_rdata_o <= {30'h0, ctrl_q};
        REG_PKTS:  reg_rdata_o <= pkts_q;
        REG_DROPS: reg_rdata_o <= drops_q;
        REG_COLL:  reg_rdata_o <= {12'h0, pct, coll_field};
        default: begin
          for (int i = 0; i < NUM_THR; i++) begin
            if (reg_addr_i == REG_THR0 + 4'(i)) reg_rdata_o <= {24'h0, thr_q[i*THR_W +: THR_W]};
          end
        end
      endcase
    end
  end

  // checks
  property p_one_seg;
    @(posedge sys_clk_i) disable iff (rst_i) blk_sop_o |-> seg_begin_o && seg_end_o && blk_valid_o;
  endproperty
  a_one_seg: assert property (p_one_seg) else $error("segment flags missing at packet start");

  property p_emit_lat;
    @(posedge sys_clk_i) disable iff (rst_i) $rose(em_busy_q) |-> ##2 (blk_sop_o && blk_valid_o);
  endproperty
  a_emit_lat: assert property (p_emit_lat) else $error("packet start not two cycles after emitter start");

  property p_version;
    @(posedge sys_clk_i) disable iff (rst_i) blk_valid_o |-> blk_data_o[STAT_HI:STAT_HI-1] == HDR_VER_1;
  endproperty
  a_version: assert property (p_version) else $error("bad header version");

  property p_strip;
    @(posedge sys_clk_i) disable iff (rst_i) dat_valid_i && dat_sa_req_i && en |=> !dat_valid_o;
  endproperty
  a_strip: assert property (p_strip) else $error("standalone request byte leaked");

  property p_pass;
    @(posedge sys_clk_i) disable iff (rst_i)
      dat_valid_i && !dat_sa_req_i |=> dat_valid_o && dat_byte_o == $past(dat_byte_i);
  endproperty
  a_pass: assert property (p_pass) else $error("data byte altered or lost");

  property p_contig;
    @(posedge sys_clk_i) disable iff (rst_i) blk_valid_o && !blk_eop_o |=> blk_valid_o && !blk_sop_o;
  endproperty
  a_contig: assert property (p_contig) else $error("gap inside packet");

  property p_same_ms;
    @(posedge sys_clk_i) disable iff (rst_i)
      blk_valid_o && !blk_sop_o |-> blk_data_o[MS_HI:MS_LO] == $past(blk_data_o[MS_HI:MS_LO]);
  endproperty
  a_same_ms: assert property (p_same_ms) else $error("minislots mixed in one packet");

  property p_frag_drop;
    @(posedge sys_clk_i) disable iff (rst_i)
      req_valid_i && req_piggy_i && req_frag_concat_i && !ms_end_i |-> !mif.wr_en ##1 col_cnt_q == $past(col_cnt_q);
  endproperty
  a_frag_drop: assert property (p_frag_drop) else $error("fragmented piggyback reported");

  property p_coll_inv;
    @(posedge sys_clk_i) disable iff (rst_i)
      mif.wr_en && mif.wr_data[COLL_HI] |-> mif.wr_data[COLL_HI-1:COLL_LO] == 3'h0 && !coll_valid;
  endproperty
  a_coll_inv: assert property (p_coll_inv) else $error("invalid collision level carries a value");

  property p_carried_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
      mif.wr_en && !req_carried_present_i |-> mif.wr_data[CARRY_HI:CARRY_LO] == 14'h0000;
  endproperty
  a_carried_zero: assert property (p_carried_zero) else $error("absent carried identifier not zero");

  c_multi_blk: cover property (@(posedge sys_clk_i) disable iff (rst_i) blk_sop_o && !blk_eop_o);
  c_drop: cover property (@(posedge sys_clk_i) disable iff (rst_i) close && em_busy_q);
  c_coll_top: cover property (@(posedge sys_clk_i) disable iff (rst_i) coll_valid && coll_lvl == 3'h7);
endmodule : urbf_framer
`default_nettype wire

// [inc/urbf_pkg.sv]
// constants and field layout for the upstream request block framer
package urbf_pkg;
  // request block layout, most significant field first
  localparam int unsigned BLK_W        = 125;
  localparam int unsigned STAT_HI      = 124;
  localparam int unsigned STAT_LO      = 117;
  localparam int unsigned COLL_HI      = 116;
  localparam int unsigned COLL_LO      = 113;
  localparam int unsigned RSV_POS      = 112;
  localparam int unsigned IUC_HI       = 111;
  localparam int unsigned IUC_LO       = 108;
  localparam int unsigned SIZE_HI      = 107;
  localparam int unsigned SIZE_LO      = 92;
  localparam int unsigned GRANT_HI     = 91;
  localparam int unsigned GRANT_LO     = 78;
  localparam int unsigned CARRY_HI     = 77;
  localparam int unsigned CARRY_LO     = 64;
  localparam int unsigned MS_HI        = 63;
  localparam int unsigned MS_LO        = 32;
  localparam int unsigned SESS_HI      = 31;
  localparam int unsigned SESS_LO      = 0;
  // status byte layout, then collision field and threshold constants
  localparam int unsigned STAT_VER_HI  = 7;
  localparam int unsigned STAT_VER_LO  = 6;
  localparam logic [1:0]  HDR_VER_1    = 2'h0;
  localparam int unsigned COLL_INV_BIT = 3;
  localparam int unsigned NUM_THR      = 7;
  localparam int unsigned THR_W        = 8;
  localparam logic [15:0] PCT_FULL     = 16'h0064;
  // register indices on the plain register port
  localparam int unsigned REG_AW       = 4;
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_THR0     = 4'h1;
  localparam logic [3:0]  REG_PKTS     = 4'h8;
  localparam logic [3:0]  REG_DROPS    = 4'h9;
  localparam logic [3:0]  REG_COLL     = 4'ha;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_COLL_BIT = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h1;
  localparam logic [7:0]  THR_RST      = 8'h00;
  typedef enum logic {URBF_EM_IDLE, URBF_EM_RUN} urbf_em_state_t;
endpackage : urbf_pkg

// [inc/urbf_mem_if.sv]
// write and read ports of the block store
`timescale 1ns/1ps
`default_nettype none
interface urbf_mem_if #(
  parameter int unsigned W  = 125,
  parameter int unsigned AW = 5
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;
  modport master (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport slave  (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface : urbf_mem_if
`default_nettype wire

// [hw/urbf_mem.sv]
// two-bank block store with registered read data
`timescale 1ns/1ps
`default_nettype none
module urbf_mem #(
  parameter int unsigned W  = 125,
  parameter int unsigned AW = 5
) (
  input  wire logic  sys_clk_i,
  urbf_mem_if.slave  mif
);
  logic [W-1:0] mem_q [2**AW];

  always_ff @(posedge sys_clk_i) begin
    if (mif.wr_en) begin
      mem_q[mif.wr_addr] <= mif.wr_data;
    end
  end

  // no reset on read data: only read after a write to the same word
  always_ff @(posedge sys_clk_i) begin
    if (mif.rd_en) begin
      mif.rd_data <= mem_q[mif.rd_addr];
    end
  end
endmodule : urbf_mem
`default_nettype wire

// [testbench/urbf_sched_model.sv]
// scheduling core model: takes request path packets and checks their framing
`timescale 1ns/1ps
`default_nettype none
module urbf_sched_model
  import urbf_pkg::*;
#(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       blk_valid_i,
  input  wire logic                       blk_sop_i,
  input  wire logic                       blk_eop_i,
  input  wire logic [BLK_W-1:0]           blk_data_i,
  input  wire logic                       seg_begin_i,
  input  wire logic                       seg_end_i,
  input  wire logic [$clog2(DEPTH+1)-1:0] seg_blocks_i
);
  // captured blocks kept for the bench; sized for a short run only
  logic [BLK_W-1:0] blk_mem [0:63];
  int               pkt_of  [0:63];
  int               nblk    = 0;
  int               pkt_cnt = 0;
  int               err_cnt = 0;
  int               cur_n   = 0;
  int               want_n  = 0;
  logic             in_pkt  = 1'b0;
  logic [31:0]      cur_ms  = 32'h0;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      in_pkt = 1'b0;
    end else begin
      if (in_pkt && !blk_valid_i) err_cnt++;
      if (blk_valid_i) begin
        if (blk_sop_i) begin
          if (in_pkt || !(seg_begin_i && seg_end_i)) err_cnt++;
          in_pkt = 1'b1;
          cur_n  = 0;
          want_n = int'(seg_blocks_i);
          cur_ms = blk_data_i[MS_HI:MS_LO];
        end else if (!in_pkt || blk_data_i[MS_HI:MS_LO] != cur_ms) begin
          err_cnt++;
        end
        blk_mem[nblk] = blk_data_i;
        pkt_of[nblk]  = pkt_cnt;
        nblk++;
        cur_n++;
        if (blk_eop_i) begin
          if (cur_n != want_n) err_cnt++;
          in_pkt = 1'b0;
          pkt_cnt++;
        end
      end
    end
  end
endmodule : urbf_sched_model
`default_nettype wire

// [testbench/upstream_request_block_framer_test.sv]
// self-checking bench for the upstream request block framer
`timescale 1ns/1ps
`default_nettype none
module upstream_request_block_framer_test;
  import urbf_pkg::*;
  localparam int DEPTH = 16;
  logic                       sys_clk_i = 1'b0;
  logic                       rst_i     = 1'b1;
  logic [3:0]                 reg_addr_i = 4'h0;
  logic [31:0]                reg_wdata_i = 32'h0, reg_rdata_o;
  logic                       reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic                       dat_valid_i = 1'b0, dat_sa_req_i = 1'b0, dat_valid_o;
  logic [7:0]                 dat_byte_i = 8'h0, dat_byte_o;
  logic                       req_valid_i = 1'b0, req_piggy_i = 1'b0, req_frag_concat_i = 1'b0;
  logic                       req_cluster_valid_i = 1'b0, req_units_i = 1'b0, req_carried_present_i = 1'b0;
  logic [2:0]                 req_cluster_i = 3'h0;
  logic [3:0]                 req_iuc_i = 4'h0;
  logic [15:0]                req_size_i = 16'h0;
  logic [13:0]                req_granted_flow_i = 14'h0, req_carried_flow_i = 14'h0;
  logic [31:0]                req_start_ms_i = 32'h0, req_session_i = 32'h0;
  logic                       ms_end_i = 1'b0, cont_opp_i = 1'b0, cont_coll_i = 1'b0;
  logic                       blk_valid_o, blk_sop_o, blk_eop_o, seg_begin_o, seg_end_o;
  logic [BLK_W-1:0]           blk_data_o;
  logic [$clog2(DEPTH+1)-1:0] seg_blocks_o;
  logic [BLK_W-1:0]           exp_q [$];
  int                         expp_q [$];
  logic [3:0]                 exp_coll = 4'h8;
  int                         n_errors = 0, n_checks = 0, cur_pkt = 0, tot = 0, rd = 0, cyc = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  urbf_framer #(.DEPTH(DEPTH), .WIN_LOG(2)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .dat_valid_i(dat_valid_i), .dat_byte_i(dat_byte_i), .dat_sa_req_i(dat_sa_req_i), .dat_valid_o(dat_valid_o),
    .dat_byte_o(dat_byte_o), .req_valid_i(req_valid_i), .req_piggy_i(req_piggy_i),
    .req_frag_concat_i(req_frag_concat_i), .req_cluster_i(req_cluster_i), .req_cluster_valid_i(req_cluster_valid_i),
    .req_units_i(req_units_i), .req_iuc_i(req_iuc_i), .req_size_i(req_size_i),
    .req_granted_flow_i(req_granted_flow_i), .req_carried_flow_i(req_carried_flow_i),
    .req_carried_present_i(req_carried_present_i), .req_start_ms_i(req_start_ms_i), .req_session_i(req_session_i),
    .ms_end_i(ms_end_i), .cont_opp_i(cont_opp_i), .cont_coll_i(cont_coll_i), .blk_valid_o(blk_valid_o),
    .blk_sop_o(blk_sop_o), .blk_eop_o(blk_eop_o), .blk_data_o(blk_data_o), .seg_begin_o(seg_begin_o),
    .seg_end_o(seg_end_o), .seg_blocks_o(seg_blocks_o));

  urbf_sched_model #(.DEPTH(DEPTH)) sched (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .blk_valid_i(blk_valid_o),
    .blk_sop_i(blk_sop_o), .blk_eop_i(blk_eop_o), .blk_data_i(blk_data_o), .seg_begin_i(seg_begin_o),
    .seg_end_i(seg_end_o), .seg_blocks_i(seg_blocks_o));

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk_blk(input logic [BLK_W-1:0] got, input logic [BLK_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_blk

  // all fields but version, piggyback, collision field, reserved bit, minislot and carried-present derive from the size, so one argument spreads over the block
  function automatic logic [BLK_W-1:0] mk_blk(input logic pg, input logic [31:0] ms, input logic [15:0] sz,
      input logic cap, input logic [3:0] coll);
    mk_blk = {HDR_VER_1, sz[2:0], sz[4], sz[5], pg, coll, 1'b0, sz[11:8], sz, sz[13:0] ^ 14'h1555,
              cap ? sz[13:0] + 14'h1 : 14'h0, ms, 32'h5e550000 | {16'h0, sz}};
  endfunction : mk_blk

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask : reg_wr

  task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk32(reg_rdata_o, e);
  endtask : chk_reg

  task automatic push_byte(input logic [7:0] b, input logic sa);
    @(posedge sys_clk_i);
    dat_valid_i  <= 1'b1;
    dat_byte_i   <= b;
    dat_sa_req_i <= sa;
    @(posedge sys_clk_i);
    dat_valid_i <= 1'b0;
    #1;
    chk32({23'h0, dat_valid_o, dat_byte_o & {8{dat_valid_o}}}, {23'h0, !sa, sa ? 8'h00 : b});
  endtask : push_byte

  task automatic send_req(input logic pg, input logic fc, input logic [31:0] ms, input logic [15:0] sz,
      input logic cap);
    @(posedge sys_clk_i);
    req_valid_i           <= 1'b1;
    req_piggy_i           <= pg;
    req_frag_concat_i     <= fc;
    req_cluster_i         <= sz[2:0];
    req_cluster_valid_i   <= sz[4];
    req_units_i           <= sz[5];
    req_iuc_i             <= sz[11:8];
    req_size_i            <= sz;
    req_granted_flow_i    <= sz[13:0] ^ 14'h1555;
    req_carried_flow_i    <= sz[13:0] + 14'h1;
    req_carried_present_i <= cap;
    req_start_ms_i        <= ms;
    req_session_i         <= 32'h5e550000 | {16'h0, sz};
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    if (!(pg && fc)) begin
      exp_q.push_back(mk_blk(pg, ms, sz, cap, exp_coll));
      expp_q.push_back(cur_pkt);
      tot++;
    end
  endtask : send_req

  // closes the minislot, waits for its packet, then compares every block captured so far
  task automatic close_ms();
    @(posedge sys_clk_i);
    ms_end_i <= 1'b1;
    @(posedge sys_clk_i);
    ms_end_i <= 1'b0;
    cur_pkt++;
    for (int i = 0; i < 40 && sched.nblk != tot; i++) @(negedge sys_clk_i);
    chk32(32'(sched.nblk), 32'(tot));
    while (rd < sched.nblk && exp_q.size() > 0) begin
      chk_blk(sched.blk_mem[rd], exp_q.pop_front());
      chk32(32'(sched.pkt_of[rd]), 32'(expp_q.pop_front()));
      rd++;
    end
  endtask : close_ms

  task automatic coll_stage(input logic [3:0] pat, input int n, input logic [3:0] f, input logic [31:0] ms);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      cont_opp_i  <= 1'b1;
      cont_coll_i <= pat[i];
      @(posedge sys_clk_i);
      cont_opp_i <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    exp_coll = f;
    send_req(1'b1, 1'b0, ms, ms[15:0] ^ 16'h2a13, 1'b1);
    close_ms();
  endtask : coll_stage

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk_reg(REG_CTRL, {30'h0, CTRL_RST});
    chk_reg(REG_THR0, 32'h0);
    chk_reg(REG_PKTS, 32'h0);
    reg_wr(4'hf, 32'hffffffff);
    chk_reg(4'hf, 32'h0);
    push_byte(8'h3c, 1'b0);
    push_byte(8'ha5, 1'b1);
    send_req(1'b0, 1'b0, 32'h00000100, 16'h1234, 1'b1);
    send_req(1'b1, 1'b0, 32'h00000100, 16'h0abc, 1'b1);
    send_req(1'b1, 1'b0, 32'h00000100, 16'hfff0, 1'b0);
    close_ms();
    send_req(1'b1, 1'b1, 32'h00000101, 16'h0055, 1'b1);
    send_req(1'b0, 1'b1, 32'h00000101, 16'h0066, 1'b1);
    close_ms();
    send_req(1'b0, 1'b0, 32'h00000200, 16'h0077, 1'b1);
    cur_pkt++;
    send_req(1'b1, 1'b0, 32'h00000201, 16'h0088, 1'b1);
    repeat (8) @(posedge sys_clk_i);
    close_ms();
    for (int i = 1; i <= 7; i++) reg_wr(REG_THR0 + 4'(i - 1), 32'(10 * i));
    reg_wr(REG_CTRL, 32'h3);
    coll_stage(4'b0101, 4, 4'h4, 32'h00000300);
    chk_reg(REG_COLL, 32'h00000324);
    coll_stage(4'b0011, 2, 4'h7, 32'h00000301);
    coll_stage(4'b0000, 4, 4'h0, 32'h00000302);
    chk_reg(REG_PKTS, 32'h7);
    send_req(1'b0, 1'b0, 32'h00000400, 16'h0111, 1'b1);
    send_req(1'b1, 1'b0, 32'h00000400, 16'h0222, 1'b1);
    // closes while the previous packet still streams, so its minislot is dropped
    send_req(1'b0, 1'b0, 32'h00000401, 16'h0333, 1'b1);
    void'(exp_q.pop_back());
    void'(expp_q.pop_back());
    tot--;
    close_ms();
    chk_reg(REG_DROPS, 32'h1);
    chk32(32'(sched.err_cnt), 32'h0);
    conclude();
  end
endmodule : upstream_request_block_framer_test
`default_nettype wire
